/* File: ptcl_pkg.sv */
// Package for the position threshold compare and capture block.
// Assumes a 10 MHz core clock; all selectors index the parameter port.
package ptcl_pkg;
  // Clock rate and the detection bound
  localparam int CLK_MHZ = 10;
  localparam int DETECT_TIME_US = 1000;
  localparam int DETECT_CYC = DETECT_TIME_US * CLK_MHZ;
  localparam int N_THR = 16;
  localparam int THR_AW = 4;
  localparam int SCAN_MARGIN = N_THR + 4;
  localparam int SEL_W = 6;
  localparam int FUNC_W = 6;
  localparam int OUT_FLD_W = 10;
  // Parameter selectors; 0x00 to 0x0F are the threshold values
  localparam logic [5:0] SEL_STATUS = 6'h10;
  localparam logic [5:0] SEL_MODE = 6'h11;
  localparam logic [5:0] SEL_SSHOT = 6'h12;
  localparam logic [5:0] SEL_EN = 6'h13;
  localparam logic [5:0] SEL_DIR = 6'h14;
  localparam logic [5:0] SEL_GNUM = 6'h15;
  localparam logic [5:0] SEL_GDEN = 6'h16;
  localparam logic [5:0] SEL_RES = 6'h17;
  localparam logic [5:0] SEL_CSRC = 6'h18;
  localparam logic [5:0] SEL_CAP_LONG = 6'h19;
  localparam logic [5:0] SEL_CAP_SHORT = 6'h1D;
  localparam logic [5:0] SEL_INFUNC = 6'h21;
  localparam logic [5:0] SEL_OUTFUNC = 6'h22;
  localparam logic [5:0] SEL_VEL = 6'h23;
  localparam logic [5:0] SEL_FBPOS = 6'h24;
  // Reset values and codes
  localparam logic [31:0] GNUM_RST = 32'h0000_2710;
  localparam logic [31:0] GDEN_RST = 32'h0010_0000;
  localparam logic [43:0] VEL_DIV = 44'h000_0000_0FA0;
  localparam logic [4:0] RES_HI = 5'h14;
  localparam logic [4:0] RES_LO = 5'h10;
  localparam logic [5:0] FN_LATCH_MOTOR = 6'h2C;
  localparam logic [5:0] FN_LATCH_EXT = 6'h2D;
  localparam logic [5:0] FN_OUT_BIT = 6'h28;
  localparam logic [5:0] FN_OUT_ANY = 6'h29;
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_CAN = 2'h2;
  localparam logic [6:0] DIV_STEPS = 7'h40;
  // Scan machine states
  typedef enum logic [1:0] {
    PTCL_IDLE = 2'b01,
    PTCL_RUN = 2'b10
  } ptcl_state_e;
endpackage

/* File: ptcl_mem_if.sv */
// Interface between the control logic and the threshold store.
// Assumes one write port and one registered read port on one clock.
`timescale 1ns/1ps
interface ptcl_mem_if #(
  parameter int AW = 4,
  parameter int DW = 32
);
  logic wr_en;
  logic [AW-1:0] waddr;
  logic [DW-1:0] wdata;
  logic [AW-1:0] raddr;
  logic [DW-1:0] rdata;
  modport ctrl (output wr_en, output waddr, output wdata, output raddr, input rdata);
  modport mem (input wr_en, input waddr, input wdata, input raddr, output rdata);
endinterface

/* File: ptcl_mem.sv */
// Threshold store: small register memory, registered read data.
// Assumes the caller holds raddr for one cycle; data follow one edge later.
`timescale 1ns/1ps
module ptcl_mem #(
  parameter int AW = 4,
  parameter int DW = 32
) (
  input wire logic clock,
  input wire logic nrst,
  ptcl_mem_if.mem bus
);
  logic [DW-1:0] mem_ff [2**AW];
  logic [DW-1:0] rdata_ff;

  // Words clear to zero at reset so every value starts at zero
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < 2**AW; i++) begin
        mem_ff[i] <= '0;
      end
    end else if (bus.wr_en) begin
      mem_ff[bus.waddr] <= bus.wdata;
    end
  end

  // Read returns the old word on a same-cycle write
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rdata_ff <= '0;
    end else begin
      rdata_ff <= mem_ff[bus.raddr];
    end
  end

  assign bus.rdata = rdata_ff;
endmodule

/* File: ptcl_top.sv */
// Position threshold compare and capture unit, with its parameter port.
// Assumes position inputs and strobes share the core clock; dig_in is async.
//
// Summary of operation
// - Sixteen signed threshold values, zero after reset.
// - Status word 32 bits, low 16 per threshold.
// - Bit 1 on overrun, or underrun if direction set.
// - Crossings flagged within one millisecond.
// - Mode 0 off, 1 on, 2 adds messages.
// - Off/on change needs save and restart.
// - Once-only threshold clears its enable on signal.
// - Sixteen-bit enable mask, zero after reset.
// - Sixteen-bit direction mask selects rising or falling.
// - Thresholds use position loop scaled units.
// - Outputs show status through functions 40, 41.
// - Input edges capture position, rise/fall separate.
// - Captures read short and long, per encoder.
// - Latch inputs assigned by functions 44, 45.
// - Scale by denominator over numerator; velocity /4000 unless numerator equals denominator.
// - Equal numerator and denominator means no scaling.
// - Resolution bits give increments per revolution.
`timescale 1ns/1ps
module ptcl_top
  import ptcl_pkg::*;
#(
  parameter int N_IN = 4,
  parameter int N_OUT = 2,
  parameter int DETECT_CYCLES = DETECT_CYC
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [SEL_W-1:0] par_sel,
  input wire logic par_wr,
  input wire logic par_rd,
  input wire logic [31:0] par_wdata,
  input wire logic par_via_can,
  input wire logic cfg_save,
  input wire logic cfg_restart,
  input wire logic pos_sample,
  input wire logic [31:0] feedback_position,
  input wire logic [31:0] motor_pos,
  input wire logic [31:0] ext_pos,
  input wire logic [N_IN-1:0] dig_in,
  output logic [31:0] par_rdata,
  output logic par_rvalid,
  output logic par_busy,
  output logic [31:0] threshold_status_word,
  output logic can_msg_req,
  output logic [N_OUT-1:0] dig_out,
  output logic [20:0] incr_per_rev
);
  // Parameter checks at elaboration
  if (N_IN < 1 || N_IN * FUNC_W > 32) begin : g_bad_in
    $error("N_IN out of range");
  end
  if (N_OUT < 1 || N_OUT * OUT_FLD_W > 32) begin : g_bad_out
    $error("N_OUT out of range");
  end
  if (DETECT_CYCLES <= SCAN_MARGIN || DETECT_CYCLES >= 2**24) begin : g_bad_det
    $error("DETECT_CYCLES out of range");
  end

  // Mask of inputs whose function field equals a code
  function automatic logic [N_IN-1:0] fmask(input logic [N_IN*FUNC_W-1:0] f, input logic [5:0] code);
    logic [N_IN-1:0] m;
    m = '0;
    for (int i = 0; i < N_IN; i++) begin
      m[i] = (f[i*FUNC_W +: FUNC_W] == code);
    end
    return m;
  endfunction

  ptcl_mem_if #(.AW(THR_AW), .DW(32)) mif ();
  ptcl_mem #(.AW(THR_AW), .DW(32)) u_mem (
    .clock(clock),
    .nrst(nrst),
    .bus(mif)
  );

  ptcl_state_e state_ff;
  ptcl_state_e nxt_state;
  logic [1:0] mode_pend_ff;
  logic [1:0] mode_nv_ff;
  logic [1:0] mode_act_ff;
  logic [15:0] sshot_ff;
  logic [15:0] en_ff;
  logic [15:0] nxt_en;
  logic [15:0] dir_ff;
  logic [15:0] status_ff;
  logic [15:0] nxt_status;
  logic [31:0] gnum_ff;
  logic [31:0] gden_ff;
  logic [4:0] res_ff;
  logic [1:0] csrc_ff;
  logic [N_IN*FUNC_W-1:0] infunc_ff;
  logic [N_OUT*OUT_FLD_W-1:0] outfunc_ff;
  logic [31:0] vel_inc_ff;
  logic [31:0] cap_ff [4];
  logic [N_IN-1:0] in_s1_ff;
  logic [N_IN-1:0] in_s2_ff;
  logic [N_IN-1:0] in_d_ff;
  logic [THR_AW-1:0] scan_idx_ff;
  logic iss_ff;
  logic [THR_AW-1:0] iss_idx_ff;
  logic [31:0] snap_ff;
  logic [23:0] wd_cnt_ff;
  logic rd_pend_ff;
  logic [SEL_W-1:0] rd_sel_ff;
  logic [31:0] par_rdata_ff;
  logic par_rvalid_ff;
  logic can_req_ff;
  logic [N_OUT-1:0] dout_ff;
  logic [20:0] ipr_ff;
  logic div_busy_ff;
  logic [6:0] div_cnt_ff;
  logic [44:0] div_rem_ff;
  logic [63:0] div_quo_ff;
  logic [43:0] div_d_ff;
  logic div_neg_ff;
  logic div_vel_ff;
  logic [THR_AW-1:0] div_idx_ff;
  logic [31:0] rd_val;

  // Write strobes per register
  wire wr_thr = par_wr && (par_sel < SEL_STATUS);
  wire wr_mode = par_wr && (par_sel == SEL_MODE);
  wire wr_sshot = par_wr && (par_sel == SEL_SSHOT);
  wire wr_en = par_wr && (par_sel == SEL_EN);
  wire wr_dir = par_wr && (par_sel == SEL_DIR);
  wire wr_gnum = par_wr && (par_sel == SEL_GNUM);
  wire wr_gden = par_wr && (par_sel == SEL_GDEN);
  wire wr_res = par_wr && (par_sel == SEL_RES);
  wire wr_csrc = par_wr && (par_sel == SEL_CSRC);
  wire wr_infunc = par_wr && (par_sel == SEL_INFUNC);
  wire wr_outfunc = par_wr && (par_sel == SEL_OUTFUNC);
  wire wr_vel = par_wr && (par_sel == SEL_VEL);

  // Mode writes: value 2 only accepted from the CAN side
  wire [1:0] mode_w = par_wdata[1:0];
  wire mode_legal = (par_wdata[31:2] == '0) && (mode_w != 2'h3)
    && ((mode_w != MODE_CAN) || par_via_can);
  wire mode_online = (mode_act_ff != MODE_OFF) && (mode_w != MODE_OFF);
  wire unit_on = (mode_act_ff != MODE_OFF);

  // Mode bookkeeping: pending, saved image and active value
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      mode_pend_ff <= MODE_OFF;
      mode_nv_ff <= MODE_OFF;
      mode_act_ff <= MODE_OFF;
    end else begin
      if (wr_mode && mode_legal) begin
        mode_pend_ff <= mode_w;
      end
      if (cfg_save) begin
        mode_nv_ff <= mode_pend_ff;
      end
      if (cfg_restart) begin
        mode_act_ff <= mode_nv_ff;
      end else if (wr_mode && mode_legal && mode_online) begin
        mode_act_ff <= mode_w;
      end
    end
  end

  // Plain configuration registers
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sshot_ff <= '0;
      dir_ff <= '0;
      gnum_ff <= GNUM_RST;
      gden_ff <= GDEN_RST;
      res_ff <= RES_HI;
      csrc_ff <= '0;
      infunc_ff <= '0;
      outfunc_ff <= '0;
    end else begin
      if (wr_sshot) sshot_ff <= par_wdata[15:0];
      if (wr_dir) dir_ff <= par_wdata[15:0];
      if (wr_gnum) gnum_ff <= par_wdata;
      if (wr_gden) gden_ff <= par_wdata;
      if (wr_res && (par_wdata[4:0] == RES_HI || par_wdata[4:0] == RES_LO)) res_ff <= par_wdata[4:0];
      if (wr_csrc) csrc_ff <= par_wdata[1:0];
      if (wr_infunc) infunc_ff <= par_wdata[N_IN*FUNC_W-1:0];
      if (wr_outfunc) outfunc_ff <= par_wdata[N_OUT*OUT_FLD_W-1:0];
    end
  end

  // Scaling divider operands; equal gears bypass the division
  wire [31:0] w_mag = par_wdata[31] ? 32'(-par_wdata) : par_wdata;
  wire [63:0] w_prod = {32'h0, w_mag} * {32'h0, gden_ff};
  wire [43:0] w_div = wr_vel ? 44'({12'h0, gnum_ff} * VEL_DIV) : {12'h0, gnum_ff};
  wire bypass = (gnum_ff == gden_ff);
  wire div_start = (wr_thr || wr_vel) && !div_busy_ff;
  wire div_fin = div_busy_ff && (div_cnt_ff == DIV_STEPS);
  wire [44:0] rem_sh = {div_rem_ff[43:0], div_quo_ff[63]};
  wire rem_ge = rem_sh >= {1'b0, div_d_ff};
  wire [31:0] div_res = div_neg_ff ? 32'(-div_quo_ff[31:0]) : div_quo_ff[31:0];

  // Restoring divider, one quotient bit per cycle; busy blocks new starts
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      div_busy_ff <= 1'b0;
      div_cnt_ff <= '0;
      div_rem_ff <= '0;
      div_quo_ff <= '0;
      div_d_ff <= '0;
      div_neg_ff <= 1'b0;
      div_vel_ff <= 1'b0;
      div_idx_ff <= '0;
    end else if (div_start) begin
      div_busy_ff <= 1'b1;
      div_cnt_ff <= bypass ? DIV_STEPS : 7'h00;
      div_rem_ff <= '0;
      div_quo_ff <= bypass ? {32'h0, w_mag} : w_prod;
      div_d_ff <= w_div;
      div_neg_ff <= par_wdata[31];
      div_vel_ff <= wr_vel;
      div_idx_ff <= par_sel[THR_AW-1:0];
    end else if (div_fin) begin
      div_busy_ff <= 1'b0;
    end else if (div_busy_ff) begin
      div_cnt_ff <= div_cnt_ff + 7'h01;
      div_rem_ff <= rem_ge ? 45'(rem_sh - {1'b0, div_d_ff}) : rem_sh;
      div_quo_ff <= {div_quo_ff[62:0], rem_ge};
    end
  end

  // Converted threshold lands in the store in increments
  assign mif.wr_en = div_fin && !div_vel_ff;
  assign mif.waddr = div_idx_ff;
  assign mif.wdata = div_res;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      vel_inc_ff <= '0;
    end else if (div_fin && div_vel_ff) begin
      vel_inc_ff <= div_res;
    end
  end

  // Host threshold reads borrow the read port; the scan waits a cycle
  wire host_thr_rd = par_rd && (par_sel < SEL_STATUS);
  wire wd_due = wd_cnt_ff >= 24'(DETECT_CYCLES - SCAN_MARGIN);
  wire scan_start = unit_on && (pos_sample || wd_due);
  wire scan_issue = (state_ff == PTCL_RUN) && !host_thr_rd;
  assign mif.raddr = host_thr_rd ? par_sel[THR_AW-1:0] : scan_idx_ff;

  // Scan sequencing
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      PTCL_IDLE: begin
        if (scan_start) nxt_state = PTCL_RUN;
      end
      PTCL_RUN: begin
        if (scan_issue && scan_idx_ff == 4'hF && !scan_start) nxt_state = PTCL_IDLE;
      end
      default: nxt_state = PTCL_IDLE;
    endcase
  end

  // A new sample restarts the pass with a fresh position snapshot
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_ff <= PTCL_IDLE;
      scan_idx_ff <= '0;
      snap_ff <= '0;
      iss_ff <= 1'b0;
      iss_idx_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      iss_ff <= scan_issue;
      iss_idx_ff <= scan_idx_ff;
      if (scan_start) begin
        scan_idx_ff <= '0;
        snap_ff <= feedback_position;
      end else if (scan_issue) begin
        scan_idx_ff <= scan_idx_ff + 4'h1;
      end
    end
  end

  // Self-triggered pass keeps detection inside the bound without samples
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wd_cnt_ff <= '0;
    end else if (scan_start || !unit_on) begin
      wd_cnt_ff <= '0;
    end else begin
      wd_cnt_ff <= wd_cnt_ff + 24'h1;
    end
  end

  // Compare the word fetched last cycle against the snapshot
  wire signed [31:0] thr_val = mif.rdata;
  wire signed [31:0] snap_val = snap_ff;
  wire hit = dir_ff[iss_idx_ff] ? (snap_val < thr_val) : (snap_val > thr_val);

  // Status and enable next values; a host enable write beats the auto-clear
  always_comb begin
    nxt_status = status_ff;
    nxt_en = en_ff;
    if (wr_en) begin
      nxt_en = par_wdata[15:0];
    end
    if (iss_ff && en_ff[iss_idx_ff]) begin
      nxt_status[iss_idx_ff] = hit;
      if (hit && sshot_ff[iss_idx_ff] && !wr_en) begin
        nxt_en[iss_idx_ff] = 1'b0;
      end
    end
    if (!unit_on) begin
      nxt_status = '0;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      status_ff <= '0;
      en_ff <= '0;
      can_req_ff <= 1'b0;
    end else begin
      status_ff <= nxt_status;
      en_ff <= nxt_en;
      can_req_ff <= (mode_act_ff == MODE_CAN) && (nxt_status != status_ff);
    end
  end

  // Pin synchronisers plus one delay stage for edge detection
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      in_s1_ff <= '0;
      in_s2_ff <= '0;
      in_d_ff <= '0;
    end else begin
      in_s1_ff <= dig_in;
      in_s2_ff <= in_s1_ff;
      in_d_ff <= in_s2_ff;
    end
  end

  // Latch triggers: function 44 feeds motor, 45 feeds external
  wire [N_IN-1:0] m_sel = fmask(infunc_ff, FN_LATCH_MOTOR) & {N_IN{csrc_ff[0]}};
  wire [N_IN-1:0] x_sel = fmask(infunc_ff, FN_LATCH_EXT) & {N_IN{csrc_ff[1]}};
  wire [N_IN-1:0] rise_v = in_s2_ff & ~in_d_ff;
  wire [N_IN-1:0] fall_v = ~in_s2_ff & in_d_ff;
  wire [3:0] cap_trig = {|(fall_v & x_sel), |(rise_v & x_sel), |(fall_v & m_sel), |(rise_v & m_sel)};

  // Captures: motor rise, motor fall, external rise, external fall
  for (genvar k = 0; k < 4; k++) begin : g_cap
    always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
        cap_ff[k] <= '0;
      end else if (cap_trig[k]) begin
        cap_ff[k] <= (k < 2) ? motor_pos : ext_pos;
      end
    end
  end

  // Digital outputs: 40 shows one selected bit, 41 shows any bit set
  for (genvar j = 0; j < N_OUT; j++) begin : g_out
    wire [5:0] fsel = outfunc_ff[j*OUT_FLD_W +: FUNC_W];
    wire [3:0] bsel = outfunc_ff[j*OUT_FLD_W+FUNC_W +: 4];
    wire oval = (fsel == FN_OUT_BIT) ? status_ff[bsel] : (fsel == FN_OUT_ANY) && (|status_ff);
    always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
        dout_ff[j] <= 1'b0;
      end else begin
        dout_ff[j] <= oval;
      end
    end
  end

  // Read decode, evaluated when the store's data are valid
  wire [5:0] cap_l = 6'(rd_sel_ff - SEL_CAP_LONG);
  wire [5:0] cap_s = 6'(rd_sel_ff - SEL_CAP_SHORT);
  always_comb begin
    rd_val = '0;
    if (rd_sel_ff < SEL_STATUS) rd_val = mif.rdata;
    else if (rd_sel_ff == SEL_STATUS) rd_val = {16'h0000, status_ff};
    else if (rd_sel_ff == SEL_MODE) rd_val = {30'h0, mode_pend_ff};
    else if (rd_sel_ff == SEL_SSHOT) rd_val = {16'h0000, sshot_ff};
    else if (rd_sel_ff == SEL_EN) rd_val = {16'h0000, en_ff};
    else if (rd_sel_ff == SEL_DIR) rd_val = {16'h0000, dir_ff};
    else if (rd_sel_ff == SEL_GNUM) rd_val = gnum_ff;
    else if (rd_sel_ff == SEL_GDEN) rd_val = gden_ff;
    else if (rd_sel_ff == SEL_RES) rd_val = {27'h0, res_ff};
    else if (rd_sel_ff == SEL_CSRC) rd_val = {30'h0, csrc_ff};
    else if (rd_sel_ff < SEL_CAP_SHORT) rd_val = cap_ff[cap_l[1:0]];
    else if (rd_sel_ff < SEL_INFUNC) rd_val = {16'h0000, cap_ff[cap_s[1:0]][15:0]};
    else if (rd_sel_ff == SEL_INFUNC) rd_val = 32'(infunc_ff);
    else if (rd_sel_ff == SEL_OUTFUNC) rd_val = 32'(outfunc_ff);
    else if (rd_sel_ff == SEL_VEL) rd_val = vel_inc_ff;
    else if (rd_sel_ff == SEL_FBPOS) rd_val = feedback_position;
  end

  // Two-edge read pipeline and the resolution output
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rd_pend_ff <= 1'b0;
      rd_sel_ff <= '0;
      par_rdata_ff <= '0;
      par_rvalid_ff <= 1'b0;
      ipr_ff <= '0;
    end else begin
      rd_pend_ff <= par_rd;
      rd_sel_ff <= par_sel;
      par_rvalid_ff <= rd_pend_ff;
      if (rd_pend_ff) par_rdata_ff <= rd_val;
      ipr_ff <= 21'h000001 << res_ff;
    end
  end

  assign par_rdata = par_rdata_ff;
  assign par_rvalid = par_rvalid_ff;
  assign par_busy = div_busy_ff;
  assign threshold_status_word = {16'h0000, status_ff};
  assign can_msg_req = can_req_ff;
  assign dig_out = dout_ff;
  assign incr_per_rev = ipr_ff;
endmodule

/* File: ptcl_top_asserts.sv */
// Checker for the threshold compare block, bound to the top ports.
// Assumes one core clock and an active-low asynchronous reset.
`timescale 1ns/1ps
module ptcl_top_asserts
  import ptcl_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic [SEL_W-1:0] par_sel,
  input wire logic par_wr,
  input wire logic par_rd,
  input wire logic [31:0] feedback_position,
  input wire logic [31:0] par_rdata,
  input wire logic par_rvalid,
  input wire logic par_busy,
  input wire logic [31:0] threshold_status_word,
  input wire logic can_msg_req,
  input wire logic [20:0] incr_per_rev
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  // Status word layout and its read path
  property p_status_hi;
    threshold_status_word[31:16] == 16'h0000;
  endproperty
  a_status_hi: assert property (p_status_hi) else $error("status upper half set");
  property p_status_rd;
    par_rd && par_sel == SEL_STATUS |-> ##2 par_rvalid && par_rdata == $past(threshold_status_word);
  endproperty
  a_status_rd: assert property (p_status_rd) else $error("status read wrong");
  // A message only follows a real status change
  property p_can_cause;
    can_msg_req |-> threshold_status_word != $past(threshold_status_word);
  endproperty
  a_can_cause: assert property (p_can_cause) else $error("message without change");
  // Conversions are started by writes and end in bounded time
  property p_busy_bound;
    $rose(par_busy) |-> ##[1:66] !par_busy;
  endproperty
  a_busy_bound: assert property (p_busy_bound) else $error("conversion too long");
  property p_busy_cause;
    $rose(par_busy) |-> $past(par_wr) && ($past(par_sel) < 6'h10 || $past(par_sel) == SEL_VEL);
  endproperty
  a_busy_cause: assert property (p_busy_cause) else $error("busy without write");
  property p_res;
    $past(nrst) |-> incr_per_rev == 21'h100000 || incr_per_rev == 21'h010000;
  endproperty
  a_res: assert property (p_res) else $error("bad increments per turn");
  // Short captures carry no upper bits; position readback is live
  property p_cap_short;
    par_rd && par_sel >= SEL_CAP_SHORT && par_sel <= 6'h20 |-> ##2 par_rdata[31:16] == 16'h0000;
  endproperty
  a_cap_short: assert property (p_cap_short) else $error("short capture too wide");
  property p_fb_rd;
    par_rd && par_sel == SEL_FBPOS |-> ##2 par_rdata == $past(feedback_position);
  endproperty
  a_fb_rd: assert property (p_fb_rd) else $error("position read wrong");
endmodule

bind ptcl_top ptcl_top_asserts i_ptcl_top_asserts (.clock, .nrst, .par_sel, .par_wr, .par_rd,
  .feedback_position, .par_rdata, .par_rvalid, .par_busy, .threshold_status_word, .can_msg_req, .incr_per_rev);

/* File: ptcl_host.sv */
// Host controller model driving the parameter port.
// Assumes one request at a time, launched just after a rising edge.
`timescale 1ns/1ps
module ptcl_host
  import ptcl_pkg::*;
(
  input wire logic clock,
  input wire logic [31:0] par_rdata,
  input wire logic par_rvalid,
  input wire logic par_busy,
  output logic [SEL_W-1:0] par_sel = 6'h3F,
  output logic par_wr = 1'b0,
  output logic par_rd = 1'b0,
  output logic [31:0] par_wdata = 32'h0,
  output logic par_via_can = 1'b0
);
  // Write, then wait for any conversion; data line scrambled after
  task automatic wr(input logic [5:0] s, input logic [31:0] d, input logic can, output logic ok);
    @(posedge clock);
    par_sel <= s;
    par_wdata <= d;
    par_via_can <= can;
    par_wr <= 1'b1;
    @(posedge clock);
    par_wr <= 1'b0;
    par_wdata <= ~d;
    par_sel <= ~s;
    @(posedge clock);
    ok = 1'b0;
    for (int i = 0; i < 100 && !ok; i++) begin
      @(negedge clock);
      ok = !par_busy;
    end
  endtask
  // Read; answer stands one cycle, two edges after the strobe
  task automatic rd(input logic [5:0] s, output logic [31:0] d, output logic v);
    @(posedge clock);
    par_sel <= s;
    par_rd <= 1'b1;
    @(posedge clock);
    par_rd <= 1'b0;
    @(posedge clock);
    @(negedge clock);
    d = par_rdata;
    v = par_rvalid;
  endtask
  // Unused thresholds written back to zero, their value after reset
  task automatic zero_unused(input logic [15:0] used);
    logic ok;
    for (int i = 0; i < N_THR; i++) begin
      if (!used[i]) wr(6'(i), 32'h0, 1'b0, ok);
    end
  endtask
endmodule

/* File: ptcl_top_test.sv */
// Self-checking bench for the threshold compare and capture block.
// Assumes the host model on the parameter port and a 10 MHz clock.
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin mismatches++; \
  $display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end
module ptcl_top_test
  import ptcl_pkg::*;
  ;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic cfg_save = 1'b0;
  logic cfg_restart = 1'b0;
  logic pos_sample = 1'b0;
  logic [31:0] feedback_position = 32'h0;
  logic [31:0] motor_pos = 32'h0;
  logic [31:0] ext_pos = 32'h0;
  logic [3:0] dig_in = 4'h0;
  wire logic [5:0] par_sel;
  wire logic par_wr, par_rd, par_via_can, par_rvalid, par_busy, can_msg_req;
  wire logic [31:0] par_wdata, par_rdata, threshold_status_word;
  wire logic [1:0] dig_out;
  wire logic [20:0] incr_per_rev;
  int mismatches = 0;
  int checks = 0;
  int can_cnt = 0;
  logic [31:0] seed = 32'h35;
  logic [31:0] d, x, p;
  logic [31:0] thr [16];
  logic [15:0] en, dir, ss, st, pst;
  logic v, ok;

  always #50 clock = ~clock;
  // Message pulses counted for the status change checks
  always @(posedge clock) if (can_msg_req === 1'b1) can_cnt++;

  ptcl_top #(.DETECT_CYCLES(64)) i_ptcl_top (.clock, .nrst, .par_sel, .par_wr, .par_rd, .par_wdata,
    .par_via_can, .cfg_save, .cfg_restart, .pos_sample, .feedback_position, .motor_pos, .ext_pos, .dig_in,
    .par_rdata, .par_rvalid, .par_busy, .threshold_status_word, .can_msg_req, .dig_out, .incr_per_rev);
  ptcl_host i_ptcl_host (.clock, .par_rdata, .par_rvalid, .par_busy, .par_sel, .par_wr, .par_rd,
    .par_wdata, .par_via_can);

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Strict compare; direction bit picks underrun
  function automatic logic hit(input logic [31:0] t, input logic [31:0] q, input logic dn);
    return dn ? ($signed(q) < $signed(t)) : ($signed(q) > $signed(t));
  endfunction
  // Magnitude scaled and truncated, sign restored
  function automatic logic [31:0] conv(input logic [31:0] u, input longint n, input longint m);
    longint a;
    a = u[31] ? -longint'($signed(u)) : longint'(u);
    a = a * m / n;
    return u[31] ? -a[31:0] : a[31:0];
  endfunction
  task automatic w(input logic [5:0] s, input logic [31:0] e);
    i_ptcl_host.wr(s, e, 1'b0, ok);
    `CHK(ok, 1'b1)
  endtask
  task automatic r(input logic [5:0] s, input logic [31:0] e);
    i_ptcl_host.rd(s, d, v);
    `CHK({v, d}, {1'b1, e})
  endtask
  task automatic strobe(input logic [2:0] m);
    @(posedge clock);
    {cfg_restart, cfg_save, pos_sample} <= m;
    @(posedge clock);
    {cfg_restart, cfg_save, pos_sample} <= 3'h0;
    repeat (25) @(posedge clock);
  endtask
  task automatic summarize();
    $display("mismatches=%0d checks=%0d", mismatches, checks);
    if (mismatches == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Hang guard
  initial begin
    repeat (90000) @(posedge clock);
    mismatches++;
    summarize();
  end

  initial begin
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    // Reset values
    r(SEL_EN, 32'h0);
    r(SEL_DIR, 32'h0);
    r(SEL_SSHOT, 32'h0);
    r(SEL_MODE, 32'h0);
    r(SEL_GNUM, GNUM_RST);
    r(SEL_GDEN, GDEN_RST);
    for (int i = 0; i < N_THR; i++) r(6'(i), 32'h0);
    `CHK(incr_per_rev, 21'h100000)
    w(SEL_RES, 32'h10);
    `CHK(incr_per_rev, 21'h010000)
    w(SEL_RES, 32'h14);
    // Scaled writes, a negative corner first
    w(SEL_GNUM, 32'h3);
    w(SEL_GDEN, 32'h7);
    for (int k = 0; k < 4; k++) begin
      x = rnd();
      x = k == 0 ? 32'hFFFF_FFFF : {{11{x[31]}}, x[31:11]};
      w(6'(k), x);
      r(6'(k), conv(x, 3, 7));
      w(SEL_VEL, {8'h0, x[23:0]});
      r(SEL_VEL, 32'(longint'(x[23:0]) * 7 / 3 / 4000));
    end
    w(SEL_GNUM, 32'h1);
    w(SEL_GDEN, 32'h1);
    // Off to on takes a save and restart
    for (int i = 0; i < 4; i++) w(6'(i), 32'h0);
    @(posedge clock);
    feedback_position <= 32'h100;
    w(SEL_MODE, 32'h1);
    w(SEL_EN, 32'hFFFF);
    strobe(3'h1);
    r(SEL_STATUS, 32'h0);
    strobe(3'h2);
    strobe(3'h4);
    can_cnt = 0;
    strobe(3'h1);
    r(SEL_STATUS, 32'hFFFF);
    `CHK(can_cnt, 0)
    i_ptcl_host.wr(SEL_MODE, 32'h2, 1'b0, ok);
    r(SEL_MODE, 32'h1);
    i_ptcl_host.wr(SEL_MODE, 32'h2, 1'b1, ok);
    r(SEL_MODE, 32'h2);
    w(SEL_OUTFUNC, {12'h0, 4'h5, FN_OUT_BIT, 4'h0, FN_OUT_ANY});
    st = 16'hFFFF;
    // Random thresholds, equal-value corner in the first pass
    for (int n = 0; n < 12; n++) begin
      w(SEL_EN, 32'h0);
      x = rnd();
      p = {{24{x[7]}}, x[7:0]};
      @(posedge clock);
      feedback_position <= p;
      for (int i = 0; i < N_THR; i++) begin
        x = rnd();
        thr[i] = n == 0 ? p : {{24{x[7]}}, x[7:0]};
        w(6'(i), thr[i]);
      end
      x = rnd();
      dir = x[15:0];
      ss = x[31:16];
      en = 16'(rnd());
      w(SEL_DIR, {16'h0, dir});
      w(SEL_SSHOT, {16'h0, ss});
      can_cnt = 0;
      w(SEL_EN, {16'h0, en});
      // Even passes rely on the self-triggered scan alone
      if (n[0]) strobe(3'h1);
      else repeat (80) @(posedge clock);
      pst = st;
      for (int i = 0; i < N_THR; i++) begin
        if (en[i]) st[i] = hit(thr[i], p, dir[i]);
        if (en[i] && st[i] && ss[i]) en[i] = 1'b0;
      end
      `CHK(threshold_status_word, {16'h0, st})
      `CHK(dig_out, {st[5], |st})
      `CHK(can_cnt != 0, pst != st)
      r(SEL_EN, {16'h0, en});
      r(6'(n), thr[n]);
      r(SEL_FBPOS, p);
    end
    // Edge captures on both encoders
    w(SEL_CSRC, 32'h3);
    w(SEL_INFUNC, {20'h0, FN_LATCH_EXT, FN_LATCH_MOTOR});
    for (int j = 0; j < 4; j++) begin
      x = rnd();
      @(posedge clock);
      motor_pos <= x;
      ext_pos <= ~x;
      dig_in[j / 2] <= (j % 2 == 0);
      repeat (6) @(posedge clock);
      p = j < 2 ? x : ~x;
      r(SEL_CAP_LONG + 6'(j), p);
      r(SEL_CAP_SHORT + 6'(j), {16'h0, p[15:0]});
    end
    i_ptcl_host.zero_unused(16'h000F);
    r(6'h0F, 32'h0);
    summarize();
  end
endmodule
